// file: src/fmid_regs.sv
// Flash control register map plus the identification bank.
// Assumes single-cycle whole-word strobes on each bus, all on clk_sys.
`timescale 1ns/100ps

module fmid_regs
  import fmid_pkg::*;
#(
  parameter int          INIT_CYCLES = 64,
  parameter logic [7:0]  MAKER_CODE  = 8'h5a,   // Arbitrary neutral value
  parameter logic [11:0] CHIP_CODE   = 12'h5a5  // Arbitrary neutral value
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              boot_source_select_pin,
  input  wire logic [3:0]        revision,
  input  wire logic              mem_rd,
  input  wire logic              mem_wr,
  input  wire logic [MEM_AW-1:0] mem_addr,
  input  wire logic [1:0]        mem_be,
  input  wire logic [15:0]       mem_wdata,
  output logic      [15:0]       mem_rdata,
  output logic                   mem_err,
  input  wire logic              per_rd,
  input  wire logic              per_wr,
  input  wire logic [PER_AW-1:0] per_addr,
  input  wire logic [1:0]        per_be,
  input  wire logic [15:0]       per_wdata,
  output logic      [15:0]       per_rdata,
  output logic                   per_err,
  input  wire logic              sfr_rd,
  input  wire logic [15:0]       sfr_addr,
  output logic      [15:0]       sfr_rdata,
  output logic                   sfr_err,
  output logic                   flash_init_done,
  output logic      [15:0]       flash_temp_unprotect_0
);

  // ****************************************
  // Helpers
  // ****************************************
  // Map a memory bus address onto a register index
  function automatic fmid_reg_t fmid_decode(input logic [MEM_AW-1:0] a);
    case (a)
      OFF_FLASH_CONTROL_0_LOW:      fmid_decode = FMID_FC0L;
      OFF_FLASH_CONTROL_0_HIGH:     fmid_decode = FMID_FC0H;
      OFF_FLASH_CONTROL_1_LOW:      fmid_decode = FMID_FC1L;
      OFF_FLASH_CONTROL_1_HIGH:     fmid_decode = FMID_FC1H;
      OFF_FLASH_DATA_0_LOW:         fmid_decode = FMID_FD0L;
      OFF_FLASH_DATA_0_HIGH:        fmid_decode = FMID_FD0H;
      OFF_FLASH_DATA_1_LOW:         fmid_decode = FMID_FD1L;
      OFF_FLASH_DATA_1_HIGH:        fmid_decode = FMID_FD1H;
      OFF_FLASH_ADDRESS_LOW:        fmid_decode = FMID_FAL;
      OFF_FLASH_ADDRESS_HIGH:       fmid_decode = FMID_FAH;
      OFF_FLASH_ERROR:              fmid_decode = FMID_FER;
      OFF_NV_WRITE_PROTECT_I:       fmid_decode = FMID_NWPI;
      OFF_NV_ACCESS_PROTECT_0:      fmid_decode = FMID_NAP0;
      OFF_NV_ACCESS_PROTECT_1_LOW:  fmid_decode = FMID_NAP1L;
      OFF_NV_ACCESS_PROTECT_1_HIGH: fmid_decode = FMID_NAP1H;
      default:                      fmid_decode = FMID_NONE;
    endcase
  endfunction : fmid_decode

  // Reset value of each memory bus register
  function automatic logic [15:0] fmid_reset(input int i);
    case (i)
      FMID_FD0L, FMID_FD0H, FMID_FD1L, FMID_FD1H: fmid_reset = RST_ONES;
      FMID_NWPI, FMID_NAP1L, FMID_NAP1H:          fmid_reset = RST_ONES;
      FMID_NAP0:                                  fmid_reset = RST_NV_ACCESS_0;
      default:                                    fmid_reset = RST_ZERO;
    endcase
  endfunction : fmid_reset

  // ****************************************
  // Flash initialization tracking
  // ****************************************
  typedef enum logic [1:0] {FMID_ST_STRAP, FMID_ST_INIT, FMID_ST_DONE} fmid_state_t;

  fmid_state_t              state;
  logic [15:0]              init_cnt;
  logic                     boot_s1;
  logic                     boot_s2;

  // Strap synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      boot_s1 <= 1'b0;
      boot_s2 <= 1'b0;
    end else begin
      boot_s1 <= boot_source_select_pin;
      boot_s2 <= boot_s1;
    end
  end

  // Strap caught after release; internal boot skips the init count and is done on the third edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state    <= FMID_ST_STRAP;
      init_cnt <= 16'h0000;
    end else begin
      case (state)
        FMID_ST_STRAP: begin
          // Synchroniser is cleared by reset, so wait until it holds the pin
          if (init_cnt != 16'(STRAP_SETTLE_CYCLES)) begin
            init_cnt <= init_cnt + 16'h0001;
          end else if (boot_s2) begin
            state    <= FMID_ST_DONE;
            init_cnt <= 16'h0000;
          end else begin
            state    <= FMID_ST_INIT;
            init_cnt <= 16'h0000;
          end
        end
        FMID_ST_INIT: begin
          if (init_cnt == 16'(INIT_CYCLES - 1)) begin
            state <= FMID_ST_DONE;
          end else begin
            init_cnt <= init_cnt + 16'h0001;
          end
        end
        FMID_ST_DONE: state <= FMID_ST_DONE;
        default:      state <= FMID_ST_STRAP;
      endcase
    end
  end

  // Not done during the strap cycles either
  assign flash_init_done = (state == FMID_ST_DONE);

  // ****************************************
  // Memory bus register file
  // ****************************************
  logic [15:0] mem_reg [NUM_MEM_REGS];
  fmid_reg_t   mem_sel;
  logic        mem_full;

  assign mem_sel  = fmid_decode(mem_addr);
  assign mem_full = (mem_be == 2'b11);

  // One process per register
  generate
    for (genvar g = 0; g < NUM_MEM_REGS; g++) begin : g_mem
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          mem_reg[g] <= fmid_reset(g);
        end else if (mem_wr && mem_full && (mem_sel == fmid_reg_t'(g))) begin
          mem_reg[g] <= mem_wdata;
        end
      end
    end
  endgenerate

  // Registered read data and error answer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mem_rdata <= 16'h0000;
      mem_err   <= 1'b0;
    end else begin
      mem_err <= (mem_rd || mem_wr) && (!mem_full || mem_sel == FMID_NONE);
      if (mem_rd && mem_full && mem_sel != FMID_NONE) begin
        mem_rdata <= mem_reg[mem_sel];
      end else if (mem_rd) begin
        mem_rdata <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Peripheral bus register
  // ****************************************
  logic per_hit;
  logic per_full;

  assign per_hit  = (per_addr == OFF_FLASH_TEMP_UNPROTECT_0);
  assign per_full = (per_be == 2'b11);

  // Temporary unprotect register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flash_temp_unprotect_0 <= RST_ZERO;
    end else if (per_wr && per_hit && per_full) begin
      flash_temp_unprotect_0 <= per_wdata;
    end
  end

  // Peripheral read data and error
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      per_rdata <= 16'h0000;
      per_err   <= 1'b0;
    end else begin
      per_err <= (per_rd || per_wr) && !(per_hit && per_full);
      if (per_rd) begin
        per_rdata <= (per_hit && per_full) ? flash_temp_unprotect_0 : 16'h0000;
      end
    end
  end

  // ****************************************
  // Identification bank
  // ****************************************
  logic id_hit;

  fmid_id_bank #(
    .MAKER_CODE (MAKER_CODE),
    .CHIP_CODE  (CHIP_CODE),
    .MEM_TYPE   (MEM_TYPE_HIGH),
    .MEM_SIZE   (MEM_SIZE_256K),
    .PROG_VDD   (PROG_SUPPLY_5V)
  ) u_id (
    .clk_sys    (clk_sys),
    .nrst       (nrst),
    .revision   (revision),
    .init_done  (flash_init_done),
    .rd_en      (sfr_rd),
    .addr       (sfr_addr),
    .rdata      (sfr_rdata),
    .hit        (id_hit)
  );

  // Unmapped identification reads flag an error
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sfr_err <= 1'b0;
    end else begin
      sfr_err <= sfr_rd && !id_hit;
    end
  end

endmodule : fmid_regs

// file: include/fmid_pkg.sv
// Package for the flash register map and identification bank.
// Assumes a 16-bit register data path and byte addresses on each bus.
package fmid_pkg;

  // ****************************************
  // Bus address widths
  // ****************************************
  localparam int MEM_AW = 20;
  localparam int PER_AW = 16;

  // ****************************************
  // Internal memory bus register offsets
  // ****************************************
  localparam logic [19:0] OFF_FLASH_CONTROL_0_LOW      = 20'h80000;
  localparam logic [19:0] OFF_FLASH_CONTROL_0_HIGH     = 20'h80002;
  localparam logic [19:0] OFF_FLASH_CONTROL_1_LOW      = 20'h80004;
  localparam logic [19:0] OFF_FLASH_CONTROL_1_HIGH     = 20'h80006;
  localparam logic [19:0] OFF_FLASH_DATA_0_LOW         = 20'h80008;
  localparam logic [19:0] OFF_FLASH_DATA_0_HIGH        = 20'h8000a;
  localparam logic [19:0] OFF_FLASH_DATA_1_LOW         = 20'h8000c;
  localparam logic [19:0] OFF_FLASH_DATA_1_HIGH        = 20'h8000e;
  localparam logic [19:0] OFF_FLASH_ADDRESS_LOW        = 20'h80010;
  localparam logic [19:0] OFF_FLASH_ADDRESS_HIGH       = 20'h80012;
  localparam logic [19:0] OFF_FLASH_ERROR              = 20'h80014;
  localparam logic [19:0] OFF_NV_WRITE_PROTECT_I       = 20'h8dfb0;
  localparam logic [19:0] OFF_NV_ACCESS_PROTECT_0      = 20'h8dfb8;
  localparam logic [19:0] OFF_NV_ACCESS_PROTECT_1_LOW  = 20'h8dfbc;
  localparam logic [19:0] OFF_NV_ACCESS_PROTECT_1_HIGH = 20'h8dfbe;

  // ****************************************
  // Peripheral bus and special-function offsets
  // ****************************************
  localparam logic [15:0] OFF_FLASH_TEMP_UNPROTECT_0   = 16'heb50;
  localparam logic [15:0] OFF_PROGRAMMING_VOLTAGE_ID   = 16'hf078;
  localparam logic [15:0] OFF_MEMORY_TYPE_SIZE_ID      = 16'hf07a;
  localparam logic [15:0] OFF_CHIP_REVISION_ID         = 16'hf07c;
  localparam logic [15:0] OFF_MANUFACTURER_ID          = 16'hf07e;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_ZERO          = 16'h0000;
  localparam logic [15:0] RST_ONES          = 16'hffff;
  localparam logic [15:0] RST_NV_ACCESS_0   = 16'hacff;

  // ****************************************
  // Identification field layout and values
  // ****************************************
  localparam int          CHIP_CODE_LSB     = 4;
  localparam int          MEM_TYPE_LSB      = 12;
  localparam int          MEM_BUSY_HI       = 15;
  localparam int          MEM_BUSY_LO       = 14;
  localparam int          EXT_PROG_LSB      = 8;
  localparam logic [3:0]  MEM_TYPE_NONE     = 4'h0;
  localparam logic [3:0]  MEM_TYPE_ROM      = 4'h1;
  localparam logic [3:0]  MEM_TYPE_STD      = 4'h2;
  localparam logic [3:0]  MEM_TYPE_HIGH     = 4'h3;
  localparam logic [11:0] MEM_SIZE_256K     = 12'h040;
  localparam logic [7:0]  PROG_SUPPLY_5V    = 8'h40;
  localparam logic [7:0]  EXT_PROG_NONE     = 8'h00;
  localparam logic [1:0]  MEM_BUSY_MARK     = 2'b11;
  localparam logic [15:0] MEM_ID_BUSY_VALUE = 16'hf040;
  // Edges after reset release until the strap synchroniser holds the pin
  localparam int          STRAP_SETTLE_CYCLES = 2;

  // Flash index for the internal memory bus register file
  typedef enum logic [3:0] {
    FMID_FC0L, FMID_FC0H, FMID_FC1L, FMID_FC1H,
    FMID_FD0L, FMID_FD0H, FMID_FD1L, FMID_FD1H,
    FMID_FAL, FMID_FAH, FMID_FER, FMID_NWPI,
    FMID_NAP0, FMID_NAP1L, FMID_NAP1H, FMID_NONE
  } fmid_reg_t;

  localparam int NUM_MEM_REGS = 15;

endpackage : fmid_pkg

// file: src/fmid_id_bank.sv
// Read-only identification bank in extended special-function space.
// Assumes a same-clock init-done level and a registered read port.
`timescale 1ns/100ps

module fmid_id_bank
  import fmid_pkg::*;
#(
  parameter logic [7:0]  MAKER_CODE = 8'h5a,   // Arbitrary neutral value
  parameter logic [11:0] CHIP_CODE  = 12'h5a5, // Arbitrary neutral value
  parameter logic [3:0]  MEM_TYPE   = MEM_TYPE_HIGH,
  parameter logic [11:0] MEM_SIZE   = MEM_SIZE_256K,
  parameter logic [7:0]  PROG_VDD   = PROG_SUPPLY_5V
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  revision,
  input  wire logic        init_done,
  input  wire logic        rd_en,
  input  wire logic [15:0] addr,
  output logic      [15:0] rdata,
  output logic             hit
);

  logic [15:0] next_rdata;

  // ****************************************
  // Read decode
  // ****************************************
  // Writes are never decoded here, so no bus write can change a field
  always_comb begin
    hit        = 1'b1;
    next_rdata = 16'h0000;
    case (addr)
      OFF_MANUFACTURER_ID:        next_rdata = {MAKER_CODE, 8'h03};
      OFF_CHIP_REVISION_ID:       next_rdata = {CHIP_CODE, revision};
      OFF_MEMORY_TYPE_SIZE_ID: begin
        if (init_done) begin
          next_rdata = {MEM_TYPE, MEM_SIZE};
        end else begin
          next_rdata = MEM_ID_BUSY_VALUE;
        end
      end
      OFF_PROGRAMMING_VOLTAGE_ID: next_rdata = {EXT_PROG_NONE, PROG_VDD};
      default:                    hit = 1'b0;
    endcase
  end

  // Registered read data
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata <= 16'h0000;
    end else if (rd_en && hit) begin
      rdata <= next_rdata;
    end
  end

endmodule : fmid_id_bank

// file: verif/fmid_regs_asserts.sv
// Concurrent checks on the flash register map and identification bank.
// Assumes one clock domain and sees only the ports of fmid_regs.
`timescale 1ns/100ps

module fmid_regs_asserts
  import fmid_pkg::*;
#(
  parameter logic [7:0]  MAKER_CODE = 8'h5a,   // Arbitrary neutral value
  parameter logic [11:0] CHIP_CODE  = 12'h5a5  // Arbitrary neutral value
) (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire logic              boot_source_select_pin,
  input wire logic [3:0]        revision,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic [1:0]        mem_be,
  input wire logic              mem_err,
  input wire logic              per_rd,
  input wire logic              per_wr,
  input wire logic [PER_AW-1:0] per_addr,
  input wire logic [1:0]        per_be,
  input wire logic [15:0]       per_wdata,
  input wire logic              per_err,
  input wire logic              sfr_rd,
  input wire logic [15:0]       sfr_addr,
  input wire logic [15:0]       sfr_rdata,
  input wire logic              sfr_err,
  input wire logic              flash_init_done,
  input wire logic [15:0]       flash_temp_unprotect_0
);
  // ****************************************
  // Identification reads
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_id_busy_value: assert property (
    sfr_rd && sfr_addr == OFF_MEMORY_TYPE_SIZE_ID && !flash_init_done
    |=> sfr_rdata == MEM_ID_BUSY_VALUE) else $error("memory id wrong before init");
  a_id_ready_value: assert property (
    sfr_rd && sfr_addr == OFF_MEMORY_TYPE_SIZE_ID && flash_init_done
    |=> sfr_rdata == 16'h3040 && !sfr_err) else $error("memory id wrong after init");
  a_prog_id_value: assert property (
    sfr_rd && sfr_addr == OFF_PROGRAMMING_VOLTAGE_ID
    |=> sfr_rdata == 16'h0040) else $error("programming id wrong");
  a_chip_id_value: assert property (
    sfr_rd && sfr_addr == OFF_CHIP_REVISION_ID
    |=> sfr_rdata == {CHIP_CODE, $past(revision)}) else $error("chip id wrong");
  a_maker_id_value: assert property (
    sfr_rd && sfr_addr == OFF_MANUFACTURER_ID
    |=> sfr_rdata == {MAKER_CODE, 8'h03}) else $error("maker id wrong");

  // ****************************************
  // Bus routing, access width, init flag
  // ****************************************
  a_partial_refused: assert property (
    (mem_rd || mem_wr) && mem_be != 2'b11 |=> mem_err) else $error("partial access taken");
  a_temp_write_lands: assert property (
    per_wr && per_be == 2'b11 && per_addr == OFF_FLASH_TEMP_UNPROTECT_0
    |=> flash_temp_unprotect_0 == $past(per_wdata) && !per_err)
    else $error("temp unprotect write lost");
  a_per_other_refused: assert property (
    (per_rd || per_wr) && per_addr != OFF_FLASH_TEMP_UNPROTECT_0 |=> per_err)
    else $error("peripheral bus took foreign address");
  a_boot_ready_fast: assert property (
    $rose(nrst) && boot_source_select_pin |-> ##[0:3] flash_init_done)
    else $error("internal boot init slow");
  a_init_done_holds: assert property (
    flash_init_done |=> flash_init_done) else $error("init done dropped");

  // Main scenarios reached
  c_busy_read: cover property (sfr_rd && !flash_init_done);
  c_mem_refused: cover property (mem_err);
  c_temp_write: cover property (per_wr && !per_err);
endmodule : fmid_regs_asserts

bind fmid_regs fmid_regs_asserts #(.MAKER_CODE(MAKER_CODE), .CHIP_CODE(CHIP_CODE)) u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .boot_source_select_pin(boot_source_select_pin),
  .revision(revision), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_be(mem_be),
  .mem_err(mem_err), .per_rd(per_rd), .per_wr(per_wr), .per_addr(per_addr),
  .per_be(per_be), .per_wdata(per_wdata), .per_err(per_err), .sfr_rd(sfr_rd),
  .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata), .sfr_err(sfr_err),
  .flash_init_done(flash_init_done), .flash_temp_unprotect_0(flash_temp_unprotect_0));

// file: verif/fmid_regs_test.sv
// Self-checking bench for the flash register map and identification bank.
// Assumes the package and fmid_regs are compiled first.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module fmid_regs_test
  import fmid_pkg::*;
;
  typedef struct packed {logic [15:0] d; logic e; logic cd;} fmid_exp_t;
  localparam logic [7:0]  MAKER = 8'h96;  // Arbitrary value
  localparam logic [11:0] CHIP  = 12'h3c7; // Arbitrary value
  logic        clk_sys = 1'b0, nrst, boot;
  logic [3:0]  revision;
  logic [2:0]  rd, wr, pend;
  logic [19:0] addr;
  logic [1:0]  be;
  logic [15:0] wdata, t, temp;
  logic [15:0] wv [15];
  logic        init_done;
  wire  [2:0]  err;
  wire  [15:0] rdat [3];
  fmid_exp_t   q [3][$];
  fmid_exp_t   ex;
  int          error_cnt, samples_checked, seed = 80;

  fmid_regs #(.INIT_CYCLES(8), .MAKER_CODE(MAKER), .CHIP_CODE(CHIP)) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .boot_source_select_pin(boot), .revision(revision),
    .mem_rd(rd[0]), .mem_wr(wr[0]), .mem_addr(addr), .mem_be(be), .mem_wdata(wdata),
    .mem_rdata(rdat[0]), .mem_err(err[0]), .per_rd(rd[1]), .per_wr(wr[1]),
    .per_addr(addr[15:0]), .per_be(be), .per_wdata(wdata), .per_rdata(rdat[1]),
    .per_err(err[1]), .sfr_rd(rd[2]), .sfr_addr(addr[15:0]), .sfr_rdata(rdat[2]),
    .sfr_err(err[2]), .flash_init_done(init_done), .flash_temp_unprotect_0(temp));

  // Clock and request tracking
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) pend <= rd | wr;

  // ****************************************
  // Result watcher
  // ****************************************
  always @(negedge clk_sys) begin
    for (int b = 0; b < 3; b++) begin
      if (pend[b] === 1'b1 && q[b].size() > 0) begin
        ex = q[b].pop_front();
        `CHK("bus error", ex.e, err[b])
        if (ex.cd) `CHK("read data", ex.d, rdat[b])
      end
    end
  end

  // ****************************************
  // Drivers and helpers
  // ****************************************
  task automatic acc(int b, bit w, logic [19:0] a, logic [1:0] bb, logic [15:0] wd,
                     logic [15:0] ed, logic ee);
    @(negedge clk_sys);
    rd = w ? 3'b000 : 3'b001 << b;
    wr = w ? 3'b001 << b : 3'b000;
    addr = a;
    be = bb;
    wdata = wd;
    q[b].push_back('{ed, ee, !w});
  endtask : acc

  task automatic idle(int n);
    repeat (n) begin
      @(negedge clk_sys);
      rd = 3'b000;
      wr = 3'b000;
    end
  endtask : idle

  task automatic do_reset(logic pin);
    @(negedge clk_sys);
    nrst = 1'b0;
    boot = pin;
    revision = 4'($random(seed));
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
  endtask : do_reset

  task automatic wait_init;
    for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge clk_sys);
    `CHK("init done", 1'b1, init_done)
  endtask : wait_init

  function automatic logic [19:0] moff(int i);
    case (i)
      11: return OFF_NV_WRITE_PROTECT_I;
      12: return OFF_NV_ACCESS_PROTECT_0;
      13: return OFF_NV_ACCESS_PROTECT_1_LOW;
      14: return OFF_NV_ACCESS_PROTECT_1_HIGH;
      default: return OFF_FLASH_CONTROL_0_LOW + 20'(2 * i);
    endcase
  endfunction : moff

  function automatic logic [15:0] rst_val(int i);
    if (i == 12) return RST_NV_ACCESS_0;
    return (i inside {[4:7], 11, 13, 14}) ? RST_ONES : RST_ZERO;
  endfunction : rst_val

  task automatic test_done;
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // Watchdog against a hung run
  initial begin
    repeat (3000) @(posedge clk_sys);
    error_cnt++;
    test_done();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    nrst = 1'b0; boot = 1'b0; revision = 4'h0; rd = 3'b000; wr = 3'b000;
    addr = 20'h00000; be = 2'b11; wdata = 16'h0000; pend = 3'b000;
    do_reset(1'b0);
    acc(2, 0, OFF_MEMORY_TYPE_SIZE_ID, 2'b11, 0, MEM_ID_BUSY_VALUE, 0);
    acc(2, 0, OFF_PROGRAMMING_VOLTAGE_ID, 2'b11, 0, 16'h0040, 0);
    acc(2, 0, OFF_CHIP_REVISION_ID, 2'b11, 0, {CHIP, revision}, 0);
    acc(2, 0, OFF_MANUFACTURER_ID, 2'b11, 0, {MAKER, 8'h03}, 0);
    idle(1);
    wait_init();
    acc(2, 0, OFF_MEMORY_TYPE_SIZE_ID, 2'b11, 0, 16'h3040, 0);
    idle(2);
    $display("Test external boot ids done");
    for (int i = 0; i < 15; i++) acc(0, 0, moff(i), 2'b11, 0, rst_val(i), 0);
    acc(1, 0, 20'(OFF_FLASH_TEMP_UNPROTECT_0), 2'b11, 0, RST_ZERO, 0);
    idle(2);
    $display("Test reset values done");
    for (int i = 0; i < 15; i++) begin
      wv[i] = 16'($random(seed));
      acc(0, 1, moff(i), 2'b11, wv[i], 0, 0);
    end
    for (int i = 0; i < 15; i++) acc(0, 0, moff(i), 2'b11, 0, wv[i], 0);
    acc(0, 1, moff(4), 2'b01, ~wv[4], 0, 1);
    acc(0, 0, moff(4), 2'b10, 0, 16'h0000, 1);
    acc(0, 0, moff(4), 2'b11, 0, wv[4], 0);
    t = 16'($random(seed));
    acc(1, 1, 20'(OFF_FLASH_TEMP_UNPROTECT_0), 2'b11, t, 0, 0);
    acc(1, 0, 20'(OFF_FLASH_TEMP_UNPROTECT_0), 2'b11, 0, t, 0);
    acc(1, 0, 20'h00000, 2'b11, 0, 16'h0000, 1);
    acc(0, 0, 20'h0eb50, 2'b11, 0, 16'h0000, 1);
    idle(2);
    `CHK("temp unprotect", t, temp)
    $display("Test write, width and routing done");
    acc(1, 1, 20'(OFF_MEMORY_TYPE_SIZE_ID), 2'b11, 16'h0000, 0, 1);
    acc(0, 1, 20'(OFF_MEMORY_TYPE_SIZE_ID), 2'b11, 16'h0000, 0, 1);
    acc(2, 0, OFF_MEMORY_TYPE_SIZE_ID, 2'b11, 0, 16'h3040, 0);
    acc(2, 0, 16'hf080, 2'b11, 0, 16'h3040, 1);
    idle(2);
    $display("Test id write and unmapped done");
    do_reset(1'b1);
    wait_init();
    acc(2, 0, OFF_MEMORY_TYPE_SIZE_ID, 2'b11, 0, 16'h3040, 0);
    acc(0, 0, moff(4), 2'b11, 0, RST_ONES, 0);
    idle(2);
    `CHK("temp after reset", RST_ZERO, temp)
    $display("Test internal boot done");
    test_done();
  end
endmodule : fmid_regs_test
